// ==== inc/imr_pkg.sv ====
/*
  Shared constants and types for the fieldbus input image of the power controller:
  word indices, value ceilings, status and command bit positions, read sequencer states
  and the packed state records of the image and its word store.
  Assumes: a single clock domain; every user of it names members as imr_pkg::name.
*/
package imr_pkg;

  // geometry of the image
  localparam int unsigned ADDR_W = 8;   // request address width, word or byte units
  localparam int unsigned IDX_W  = 4;   // word index width inside the image
  localparam int unsigned DATA_W = 16;  // every location is one 16-bit word
  localparam int unsigned DEPTH  = 10;  // words 0 .. 9

  // word indices; byte offset is twice the index
  localparam logic [3:0] W_UNUSED0   = 4'h0;
  localparam logic [3:0] W_UNUSED1   = 4'h1;
  localparam logic [3:0] W_LINE_FREQ = 4'h2;
  localparam logic [3:0] W_OUT_VOLT  = 4'h3;
  localparam logic [3:0] W_OUT_CURR  = 4'h4;
  localparam logic [3:0] W_OUT_POWER = 4'h5;
  localparam logic [3:0] W_STATUS    = 4'h6;
  localparam logic [3:0] W_CMD_RB    = 4'h7;
  localparam logic [3:0] W_SETPOINT  = 4'h8;
  localparam logic [3:0] W_OUT_SCALE = 4'h9;
  localparam logic [3:0] W_LAST      = 4'h9;

  // per-word ceilings; the floor is always zero
  localparam logic [15:0] MAX_FREQ     = 16'hFFFF;
  localparam logic [15:0] MAX_VOLT     = 16'h270F;
  localparam logic [15:0] MAX_CURR     = 16'h270F;
  localparam logic [15:0] MAX_POWER    = 16'h0064;
  localparam logic [15:0] MAX_SETPOINT = 16'h03FF;
  localparam logic [15:0] MAX_SCALE    = 16'h00FF;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;

  // status word bit positions
  localparam int unsigned ST_SCR_SHORT    = 0;
  localparam int unsigned ST_HEATER_BREAK = 1;
  localparam int unsigned ST_OUT_ENABLED  = 2;
  localparam int unsigned ST_CURR_LIMIT   = 4;
  localparam int unsigned ST_THERMAL      = 5;
  localparam int unsigned ST_COMM         = 6;
  localparam int unsigned ST_DIG_IN1      = 8;
  localparam int unsigned ST_DIG_IN2      = 9;
  localparam int unsigned ST_UNBALANCE    = 10;
  localparam int unsigned ST_PHASE_LOSS   = 13;
  localparam int unsigned ST_BAKEOUT      = 14;
  localparam int unsigned ST_THERM_LATCH  = 15;

  // command readback bit positions
  localparam int unsigned CB_SP_LOCAL   = 1;
  localparam int unsigned CB_OUT_ENABLE = 2;
  localparam int unsigned CB_ILIM_LOCAL = 4;

  // read sequencer
  typedef enum logic [1:0] {IMR_IDLE, IMR_FETCH, IMR_ANSWER} imr_rd_state_t;

  // all state of the image top
  typedef struct packed {
    logic                  di1_meta;     // first sync stage, input 1
    logic                  di1_sync;     // second sync stage, input 1
    logic                  di2_meta;     // first sync stage, input 2
    logic                  di2_sync;     // second sync stage, input 2
    logic [IDX_W-1:0]      refresh_idx;  // word being refreshed this cycle
    imr_rd_state_t         rd_state;     // read sequencer
    logic                  rd_err;       // request hit no word
    logic [DATA_W-1:0]     rd_data;      // answer word
    logic                  sp_local;     // set point source in force
    logic                  out_en;       // output enable in force
  } imr_state_t;

  // all state of the word store
  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] words;  // image contents
    logic [DATA_W-1:0]            rdata;  // registered read word
  } imr_store_t;

endpackage

// ==== test/imr_fieldbus_master.sv ====
/*
  Behavioural fieldbus engine that issues single reads into the input image.
  Assumes: one clock; the caller enters read 1 ns after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module imr_fieldbus_master (
  input  wire logic                       clk,
  input  wire logic                       rd_ack,
  input  wire logic [imr_pkg::DATA_W-1:0] rd_data,
  input  wire logic                       rd_err,
  output var  logic                       rd_req,
  output var  logic                       rd_byte_mode,
  output var  logic [imr_pkg::ADDR_W-1:0] rd_addr
);
  // idle at time zero
  initial
  begin
    rd_req       = 1'b0;
    rd_byte_mode = 1'b0;
    rd_addr      = 8'h00;
  end

  // one read; gap idles first, so prompt and slow masters both occur
  task automatic read(input logic bm, input logic [imr_pkg::ADDR_W-1:0] addr, input int gap,
                      output logic [imr_pkg::DATA_W-1:0] data, output logic err, output bit ok);
    ok = 1'b0;
    repeat (gap + 1)
    begin
      @(posedge clk);
      #1;
    end
    rd_req       = 1'b1;
    rd_byte_mode = bm;
    rd_addr      = addr;
    // request held until the acknowledge is seen at an edge, for at most 8 edges
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge clk);
      if (rd_ack === 1'b1)
      begin
        data = rd_data;
        err  = rd_err;
        ok   = 1'b1;
      end
    end
    #1;
    // released lines do not keep their last value
    rd_req       = 1'b0;
    rd_byte_mode = ~rd_byte_mode;
    rd_addr      = ~rd_addr;
  endtask
endmodule

`default_nettype wire

// ==== test/imr_input_image_tb.sv ====
/*
  Self-checking bench of the fieldbus input image: map, clamps, flags, controls.
  Assumes: the read engine model in imr_fieldbus_master; 10 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

module imr_input_image_tb;
  logic                         sys_clk, rst, rd_req, rd_byte_mode, rd_ack, rd_err, sp_local, out_en;
  logic [imr_pkg::ADDR_W-1:0]   rd_addr;
  logic [imr_pkg::DATA_W-1:0]   rd_data, line_freq, out_volt, out_curr, out_power, setpoint, out_scale;
  logic [8:0]                   alm;    // alarm flags in status bit order
  logic [2:0]                   cmd;    // ilim local, out enable, sp local
  logic [4:0]                   cfg;    // rw, di sel sp, di en out, dig in 1, dig in 2
  logic [15:0]                  got;    // last answer
  logic                         gerr;   // last error flag
  bit                           ok;     // answer arrived in time
  int                           miscompares, n_tests;
  int                           apos [9] = '{0, 1, 4, 5, 6, 10, 13, 14, 15};
  // expected image with clamping applied
  logic [15:0]                  wexp [10] = '{16'h0000, 16'h0000, 16'hC350, 16'h270F, 16'h1234,
                                              16'h0064, 16'h0000, 16'h0000, 16'h03FF, 16'h00FF};
  // rw, sel, en, di1, di2, cmd en, cmd sp -> sp local, out enabled
  logic [8:0]                   mode [4] = '{9'h0F3, 9'h1F0, 9'h1CE, 9'h159};

  imr_input_image imr_input_image_i (
    .SYS_CLK(sys_clk), .RST(rst), .RD_REQ(rd_req), .RD_BYTE_MODE(rd_byte_mode), .RD_ADDR(rd_addr),
    .RD_ACK(rd_ack), .RD_DATA(rd_data), .RD_ERR(rd_err), .LINE_FREQ(line_freq), .OUT_VOLT(out_volt),
    .OUT_CURR(out_curr), .OUT_POWER(out_power), .ALM_SCR_SHORT(alm[0]), .ALM_HEATER_BREAK(alm[1]),
    .ALM_CURR_LIMIT(alm[2]), .ALM_THERMAL(alm[3]), .ALM_COMM(alm[4]), .ALM_UNBALANCE(alm[5]),
    .ALM_PHASE_LOSS(alm[6]), .BAKEOUT_ON(alm[7]), .ALM_THERM_LATCHED(alm[8]), .DIG_IN1(cfg[1]),
    .DIG_IN2(cfg[0]), .CMD_SP_LOCAL(cmd[0]), .CMD_OUT_ENABLE(cmd[1]), .CMD_ILIM_LOCAL(cmd[2]),
    .SETPOINT(setpoint), .OUT_SCALE(out_scale), .PORT_RW_ACCESS(cfg[4]), .DI_SELECTS_SP(cfg[3]),
    .DI_ENABLES_OUT(cfg[2]), .SETPOINT_LOCAL(sp_local), .OUTPUT_ENABLED(out_en));

  imr_fieldbus_master imr_fieldbus_master_i (
    .clk(sys_clk), .rd_ack(rd_ack), .rd_data(rd_data), .rd_err(rd_err),
    .rd_req(rd_req), .rd_byte_mode(rd_byte_mode), .rd_addr(rd_addr));

  // free-running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // inputs move 1 ns after an edge, never on it
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one read through the engine model, data and error compared
  task automatic rd(input logic bm, input logic [7:0] a, input logic [15:0] e, input logic ee);
    imr_fieldbus_master_i.read(bm, a, int'(a[1:0]), got, gerr, ok);
    if (!ok)
    begin
      miscompares++;
      results();
    end
    else
    begin
      chk(got, e);
      chk({15'h0000, gerr}, {15'h0000, ee});
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    {line_freq, out_volt, out_curr} = {16'hC350, 16'hFFFF, 16'h1234};
    {out_power, setpoint, out_scale} = {16'h00C8, 16'h0400, 16'h00FF};
    {alm, cmd, cfg} = 17'h0_0000;
    miscompares = 0;
    n_tests = 0;
    tick(6);
    chk(rd_data, 16'h0000);
    chk({12'h000, rd_ack, rd_err, sp_local, out_en}, 16'h0000);
    rst = 1'b0;
    tick(12);
    // whole map by word and byte offset; clamps on volts, power, set point
    for (int i = 0; i < 10; i++)
    begin
      rd(1'b0, 8'(i), wexp[i], 1'b0);
      rd(1'b1, 8'(2 * i), wexp[i], 1'b0);
    end
    rd(1'b0, 8'h0A, 16'h0000, 1'b1);
    rd(1'b1, 8'h0D, 16'h0000, 1'b1);
    rd(1'b1, 8'h14, 16'h0000, 1'b1);
    $display("test map done");
    // each alarm alone lands on its own bit
    for (int i = 0; i < 9; i++)
    begin
      alm = 9'(1 << i);
      tick(16);
      rd(1'b1, 8'h0C, 16'(1 << apos[i]), 1'b0);
    end
    // all alarms, both inputs and all commands on, config bits off: unused bits must stay clear
    {alm, cfg, cmd} = {9'h1FF, 5'h03, 3'h7};
    tick(16);
    rd(1'b1, 8'h0C, 16'hE777, 1'b0);
    rd(1'b0, 8'h07, 16'h0016, 1'b0);
    {alm, cmd} = 12'h000;
    for (int j = 0; j < 3; j++)
    begin
      cmd = 3'(1 << j);
      // a full refresh round must pass before word 7 shows the new command
      tick(12);
      rd(1'b1, 8'h0E, (j == 2) ? 16'h0010 : 16'h0002 << j, 1'b0);
    end
    $display("test flags done");
    // source and enable resolution with and without write access
    cmd = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      {cfg, cmd[1:0]} = mode[i][8:2];
      tick(16);
      chk({14'h0000, sp_local, out_en}, {14'h0000, mode[i][1:0]});
      rd(1'b0, 8'h06, {6'h00, cfg[0], cfg[1], 5'h00, mode[i][0], 2'h0}, 1'b0);
      rd(1'b1, 8'h0E, {13'h0000, cmd[1:0], 1'b0}, 1'b0);
    end
    $display("test controls done");
    results();
  end
endmodule

`default_nettype wire

// ==== verilog/imr_input_image.sv ====
/*
  Read-only input image of the power controller as seen by a fieldbus master:
  live measurements, alarm and status flags, command readback, set point and
  output scaling, reachable by word index or by byte offset.
  Assumes: measurement, alarm and command inputs come from logic on SYS_CLK;
  the two digital inputs are raw pins; the protocol engine issues single reads.
*/
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - image is read-only from the fieldbus
// - numeric words unsigned, clamped to their ceiling
// - byte offset twice word offset, same word
// - status bit 0 shows thyristor short alarm
// - status bit 1 shows heater break alarm
// - status bit 2 shows output enabled
// - status bit 4 shows current limit alarm
// - status bit 5 shows thermal alarm
// - status bit 6 shows communication alarm
// - status bits 8, 9 mirror digital inputs
// - status bit 10 shows load unbalance alarm
// - status bit 13 shows phase loss alarm
// - status bit 14 shows bakeout running
// - status bit 15 shows latched thermal alarm
// - status bits 3, 7, 11, 12 read zero
// - command bit 1 shows local set point
// - command bit 2 shows output commanded on
// - command bit 4 shows local current limit
// - set point word holds zero to 1023
// - scaling word holds zero to 255
// - read-write port: set point source from command
// - read-write port with input enable: enable needs input and command
module imr_input_image (
  input  wire logic                         SYS_CLK,
  input  wire logic                         RST,
  // read port toward the fieldbus engine
  input  wire logic                         RD_REQ,
  input  wire logic                         RD_BYTE_MODE,
  input  wire logic [imr_pkg::ADDR_W-1:0]   RD_ADDR,
  output logic                              RD_ACK,
  output logic      [imr_pkg::DATA_W-1:0]   RD_DATA,
  output logic                              RD_ERR,
  // live measurements
  input  wire logic [imr_pkg::DATA_W-1:0]   LINE_FREQ,
  input  wire logic [imr_pkg::DATA_W-1:0]   OUT_VOLT,
  input  wire logic [imr_pkg::DATA_W-1:0]   OUT_CURR,
  input  wire logic [imr_pkg::DATA_W-1:0]   OUT_POWER,
  // alarm and state flags
  input  wire logic                         ALM_SCR_SHORT,
  input  wire logic                         ALM_HEATER_BREAK,
  input  wire logic                         ALM_CURR_LIMIT,
  input  wire logic                         ALM_THERMAL,
  input  wire logic                         ALM_COMM,
  input  wire logic                         ALM_UNBALANCE,
  input  wire logic                         ALM_PHASE_LOSS,
  input  wire logic                         BAKEOUT_ON,
  input  wire logic                         ALM_THERM_LATCHED,
  // digital input pins
  input  wire logic                         DIG_IN1,
  input  wire logic                         DIG_IN2,
  // holding values written by the master elsewhere
  input  wire logic                         CMD_SP_LOCAL,
  input  wire logic                         CMD_OUT_ENABLE,
  input  wire logic                         CMD_ILIM_LOCAL,
  input  wire logic [imr_pkg::DATA_W-1:0]   SETPOINT,
  input  wire logic [imr_pkg::DATA_W-1:0]   OUT_SCALE,
  // configuration
  input  wire logic                         PORT_RW_ACCESS,
  input  wire logic                         DI_SELECTS_SP,
  input  wire logic                         DI_ENABLES_OUT,
  // resolved controls
  output logic                              SETPOINT_LOCAL,
  output logic                              OUTPUT_ENABLED
);

  imr_pkg::imr_state_t          state;       // all registered state
  imr_pkg::imr_state_t          next_state;  // its next value
  logic [imr_pkg::DATA_W-1:0]   wr_word;     // word refreshed this cycle
  logic [imr_pkg::DATA_W-1:0]   status_word; // packed alarm and state flags
  logic [imr_pkg::DATA_W-1:0]   cmd_word;    // packed command readback
  logic                         req_taken;   // read accepted this cycle
  logic [imr_pkg::ADDR_W-1:0]   req_word;    // requested word index, full width
  logic                         req_bad;     // request misses the image
  logic [imr_pkg::DATA_W-1:0]   mem_rdata;   // registered store output

  // clip a measurement to its ceiling; the floor is zero since all are unsigned
  function automatic logic [imr_pkg::DATA_W-1:0] clamp_word(
    input logic [imr_pkg::DATA_W-1:0] value,
    input logic [imr_pkg::DATA_W-1:0] ceiling
  );
    return (value > ceiling) ? ceiling : value;
  endfunction

  // byte addressing halves the offset, word addressing uses it as is
  function automatic logic [imr_pkg::ADDR_W-1:0] word_of(
    input logic                       byte_mode,
    input logic [imr_pkg::ADDR_W-1:0] addr
  );
    return byte_mode ? {1'b0, addr[imr_pkg::ADDR_W-1:1]} : addr;
  endfunction

  // odd byte offsets split a word, so they are refused like unmapped ones
  function automatic logic addr_bad(
    input logic                       byte_mode,
    input logic [imr_pkg::ADDR_W-1:0] addr
  );
    return (byte_mode && addr[0]) || (word_of(byte_mode, addr) > {4'h0, imr_pkg::W_LAST});
  endfunction

  assign req_taken = (state.rd_state == imr_pkg::IMR_IDLE) && RD_REQ;
  assign req_word  = word_of(RD_BYTE_MODE, RD_ADDR);
  assign req_bad   = addr_bad(RD_BYTE_MODE, RD_ADDR);

  // status flags; unused positions stay zero from the default
  always_comb
  begin
    status_word = imr_pkg::ZERO_WORD;
    status_word[imr_pkg::ST_SCR_SHORT]    = ALM_SCR_SHORT;
    status_word[imr_pkg::ST_HEATER_BREAK] = ALM_HEATER_BREAK;
    status_word[imr_pkg::ST_OUT_ENABLED]  = state.out_en;
    status_word[imr_pkg::ST_CURR_LIMIT]   = ALM_CURR_LIMIT;
    status_word[imr_pkg::ST_THERMAL]      = ALM_THERMAL;
    status_word[imr_pkg::ST_COMM]         = ALM_COMM;
    status_word[imr_pkg::ST_DIG_IN1]      = state.di1_sync;
    status_word[imr_pkg::ST_DIG_IN2]      = state.di2_sync;
    status_word[imr_pkg::ST_UNBALANCE]    = ALM_UNBALANCE;
    status_word[imr_pkg::ST_PHASE_LOSS]   = ALM_PHASE_LOSS;
    status_word[imr_pkg::ST_BAKEOUT]      = BAKEOUT_ON;
    status_word[imr_pkg::ST_THERM_LATCH]  = ALM_THERM_LATCHED;
  end

  // command readback mirrors what the master asked for, not what is in force
  always_comb
  begin
    cmd_word = imr_pkg::ZERO_WORD;
    cmd_word[imr_pkg::CB_SP_LOCAL]   = CMD_SP_LOCAL;
    cmd_word[imr_pkg::CB_OUT_ENABLE] = CMD_OUT_ENABLE;
    cmd_word[imr_pkg::CB_ILIM_LOCAL] = CMD_ILIM_LOCAL;
  end

  // word for the refresh slot; a round robin keeps the store one mux wide
  // at the price of up to ten cycles of staleness per word
  always_comb
  begin
    case (state.refresh_idx)
      imr_pkg::W_UNUSED0:   wr_word = imr_pkg::ZERO_WORD;
      imr_pkg::W_UNUSED1:   wr_word = imr_pkg::ZERO_WORD;
      imr_pkg::W_LINE_FREQ: wr_word = clamp_word(LINE_FREQ, imr_pkg::MAX_FREQ);
      imr_pkg::W_OUT_VOLT:  wr_word = clamp_word(OUT_VOLT, imr_pkg::MAX_VOLT);
      imr_pkg::W_OUT_CURR:  wr_word = clamp_word(OUT_CURR, imr_pkg::MAX_CURR);
      imr_pkg::W_OUT_POWER: wr_word = clamp_word(OUT_POWER, imr_pkg::MAX_POWER);
      imr_pkg::W_STATUS:    wr_word = status_word;
      imr_pkg::W_CMD_RB:    wr_word = cmd_word;
      imr_pkg::W_SETPOINT:  wr_word = clamp_word(SETPOINT, imr_pkg::MAX_SETPOINT);
      imr_pkg::W_OUT_SCALE: wr_word = clamp_word(OUT_SCALE, imr_pkg::MAX_SCALE);
      default:              wr_word = imr_pkg::ZERO_WORD;
    endcase
  end

  // next state: pin sync, refresh pointer, control resolution, read sequencer
  always_comb
  begin
    next_state = state;
    // two stages before anything looks at the pins
    next_state.di1_meta = DIG_IN1;
    next_state.di1_sync = state.di1_meta;
    next_state.di2_meta = DIG_IN2;
    next_state.di2_sync = state.di2_meta;
    // walk words 0 .. 9 and wrap
    if (state.refresh_idx >= imr_pkg::W_LAST)
    begin
      next_state.refresh_idx = imr_pkg::W_UNUSED0;
    end
    else
    begin
      next_state.refresh_idx = state.refresh_idx + 4'h1;
    end
    // set point source: fieldbus command wins when it may write
    if (PORT_RW_ACCESS)
    begin
      next_state.sp_local = CMD_SP_LOCAL;
    end
    else if (DI_SELECTS_SP)
    begin
      next_state.sp_local = state.di1_sync;
    end
    else
    begin
      next_state.sp_local = CMD_SP_LOCAL;
    end
    // output enable: input and command must agree when both have a say
    if (DI_ENABLES_OUT && PORT_RW_ACCESS)
    begin
      next_state.out_en = state.di2_sync && CMD_OUT_ENABLE;
    end
    else if (DI_ENABLES_OUT)
    begin
      next_state.out_en = state.di2_sync;
    end
    else
    begin
      next_state.out_en = CMD_OUT_ENABLE;
    end
    // read sequencer; no write path exists at all
    case (state.rd_state)
      imr_pkg::IMR_IDLE:
      begin
        if (RD_REQ)
        begin
          next_state.rd_err   = req_bad;
          next_state.rd_state = imr_pkg::IMR_FETCH;
        end
      end
      imr_pkg::IMR_FETCH:
      begin
        // refused requests answer zero, never a neighbouring word
        next_state.rd_data  = state.rd_err ? imr_pkg::ZERO_WORD : mem_rdata;
        next_state.rd_state = imr_pkg::IMR_ANSWER;
      end
      imr_pkg::IMR_ANSWER:
      begin
        next_state.rd_state = imr_pkg::IMR_IDLE;
      end
      default:
      begin
        next_state.rd_state = imr_pkg::IMR_IDLE;
      end
    endcase
  end

  // single state register
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // image storage, refreshed one word per cycle
  imr_word_store u_store (
    .clk   (SYS_CLK),
    .rst   (RST),
    .we    (1'b1),
    .waddr (state.refresh_idx),
    .wdata (wr_word),
    .re    (req_taken),
    .raddr (req_word[imr_pkg::IDX_W-1:0]),
    .rdata (mem_rdata)
  );

  assign RD_ACK         = (state.rd_state == imr_pkg::IMR_ANSWER);
  assign RD_DATA        = state.rd_data;
  assign RD_ERR         = state.rd_err;
  assign SETPOINT_LOCAL = state.sp_local;
  assign OUTPUT_ENABLED = state.out_en;

  // checks on the block's outputs and internal refresh and status words
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  sequence s_req_taken;
    req_taken;
  endsequence

  sequence s_answer;
    RD_ACK ##1 !RD_ACK;
  endsequence

  property p_read_latency;
    s_req_taken |-> ##1 !RD_ACK ##1 s_answer;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer not two cycles after request");

  property p_unused_zero;
    (req_taken && !req_bad && (req_word <= {4'h0, imr_pkg::W_UNUSED1})) |-> ##2 (RD_ACK && (RD_DATA == imr_pkg::ZERO_WORD));
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused word did not read zero");

  property p_odd_byte;
    (req_taken && RD_BYTE_MODE && RD_ADDR[0]) |-> ##2 (RD_ACK && RD_ERR && (RD_DATA == imr_pkg::ZERO_WORD));
  endproperty
  a_odd_byte: assert property (p_odd_byte) else $error("odd byte offset not refused");

  property p_byte_word_same;
    (req_taken && RD_BYTE_MODE && !RD_ADDR[0] && (RD_ADDR <= {3'h0, imr_pkg::W_LAST, 1'b0}))
      |-> (req_word[imr_pkg::IDX_W-1:0] == RD_ADDR[imr_pkg::IDX_W:1]) ##2 (RD_ACK && !RD_ERR);
  endproperty
  a_byte_word_same: assert property (p_byte_word_same) else $error("even byte offset not served as its word");

  property p_volt_ceiling;
    (state.refresh_idx == imr_pkg::W_OUT_VOLT) |-> (wr_word <= imr_pkg::MAX_VOLT);
  endproperty
  a_volt_ceiling: assert property (p_volt_ceiling) else $error("output voltage above ceiling");

  property p_status_unused;
    (state.refresh_idx == imr_pkg::W_STATUS) |-> (wr_word[3] == 1'b0 && wr_word[7] == 1'b0 && wr_word[11] == 1'b0 && wr_word[12] == 1'b0);
  endproperty
  a_status_unused: assert property (p_status_unused) else $error("unused status bit set");

  property p_status_enable;
    (state.refresh_idx == imr_pkg::W_STATUS) |-> (wr_word[imr_pkg::ST_OUT_ENABLED] == OUTPUT_ENABLED);
  endproperty
  a_status_enable: assert property (p_status_enable) else $error("status enable bit disagrees with output");

  property p_di_mirror;
    $stable(DIG_IN1) [*3] |-> (status_word[imr_pkg::ST_DIG_IN1] == DIG_IN1);
  endproperty
  a_di_mirror: assert property (p_di_mirror) else $error("digital input 1 not mirrored");

  property p_sp_local;
    PORT_RW_ACCESS |=> (SETPOINT_LOCAL == $past(CMD_SP_LOCAL));
  endproperty
  a_sp_local: assert property (p_sp_local) else $error("set point source ignores command");

  property p_out_enable;
    (PORT_RW_ACCESS && DI_ENABLES_OUT) |=> (OUTPUT_ENABLED == ($past(status_word[imr_pkg::ST_DIG_IN2]) && $past(CMD_OUT_ENABLE)));
  endproperty
  a_out_enable: assert property (p_out_enable) else $error("output enable without both input and command");

endmodule

`default_nettype wire

// ==== verilog/imr_word_store.sv ====
/*
  Word store of the input image: ten 16-bit words, one write port and one
  read port whose data come out of a register on a read enable.
  Assumes: one clock, asynchronous active-high reset, writer keeps waddr in range.
*/
`timescale 1ns/1ns
`default_nettype none

module imr_word_store (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         we,
  input  wire logic [imr_pkg::IDX_W-1:0]    waddr,
  input  wire logic [imr_pkg::DATA_W-1:0]   wdata,
  input  wire logic                         re,
  input  wire logic [imr_pkg::IDX_W-1:0]    raddr,
  output logic      [imr_pkg::DATA_W-1:0]   rdata
);

  imr_pkg::imr_store_t state;       // registered store
  imr_pkg::imr_store_t next_state;  // its next value

  // write and read select; out-of-range reads give zero rather than x
  always_comb
  begin
    next_state = state;
    if (we && (waddr <= imr_pkg::W_LAST))
    begin
      next_state.words[waddr] = wdata;
    end
    if (re)
    begin
      next_state.rdata = (raddr <= imr_pkg::W_LAST) ? state.words[raddr] : imr_pkg::ZERO_WORD;
    end
  end

  // zeroed at reset so an early read never sees garbage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;

endmodule

`default_nettype wire
